// file: bench/pdg_hook_relay_model.sv
// hook relay model: counts line breaks and times break, make and idle
`timescale 1ns/1ps
module pdg_hook_relay_model (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic hookRelay, // 1 closes the loop
  input wire logic clr, // clears counts
  output logic [4:0] pulses, // breaks seen
  output int brkLen, // last break, cycles
  output int mkLen, // last make between breaks, cycles
  output int sinceRise // cycles since loop closed
);
  logic prevQ;
  int runQ;
  always_ff @(posedge ref_clk) begin
    prevQ <= hookRelay;
    if (!rst_b || clr) begin
      pulses <= 5'h00;
      brkLen <= 0;
      mkLen <= 0;
      runQ <= 0;
      sinceRise <= 0;
    end else begin
      runQ <= (hookRelay != prevQ) ? 1 : runQ + 1;
      sinceRise <= sinceRise + 1;
      if (prevQ && !hookRelay) begin
        pulses <= pulses + 5'h01;
        if (pulses != 5'h00) begin
          mkLen <= runQ;
        end
      end
      if (!prevQ && hookRelay) begin
        brkLen <= runQ;
        sinceRise <= 1;
      end
    end
  end
endmodule

// file: bench/pdg_pulse_dial_bench.sv
// self-checking bench of the pulse dial generator
`timescale 1ns/1ps
module pdg_pulse_dial_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dialToggle = 1'b0;
  logic clr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seedVal;
  logic pready, pslverr, hookRelay, pulseDialing, err;
  logic [4:0] pulses;
  logic [1:0] gen, brk, pau;
  logic [3:0] dig;
  int brkLen, mkLen, sinceRise, snap;
  int mismatches = 0;
  int numChecks = 0;
  logic [31:0] brkTab[4] = '{32'h3C, 32'h43, 32'h28, 32'h40};
  logic [31:0] mkTab[4] = '{32'h28, 32'h21, 32'h16, 32'h2A};
  logic [31:0] pauTab[4] = '{32'h320, 32'h352, 32'h3B6, 32'h258};
  always #2 ref_clk = ~ref_clk;

  pdg_pulse_dial #(.CYC_PER_MS(1)) i_pdg_pulse_dial (.ref_clk(ref_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dialToggle(dialToggle),
    .hookRelay(hookRelay), .pulseDialing(pulseDialing));
  pdg_hook_relay_model i_pdg_hook_relay_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .hookRelay(hookRelay), .clr(clr), .pulses(pulses), .brkLen(brkLen), .mkLen(mkLen),
    .sinceRise(sinceRise));

  task automatic completeRun;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic checkSpan(input string name, input int lo, input int seen);
    numChecks++;
    if (seen < lo || seen > lo + 10) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", name, lo, seen);
    end
  endtask

  function automatic logic [31:0] expPulses(input logic [1:0] g, input logic [3:0] d);
    case (g)
      2'h1: return {28'h0, d} + 32'h1;
      2'h2: return 32'hA - {28'h0, d};
      default: return (d == 4'h0) ? 32'hA : {28'h0, d};
    endcase
  endfunction

  // one transfer; one idle edge first, pready and data taken at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        check("pready wait", 32'h1, 32'h0);
        completeRun();
      end
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    snap = sinceRise;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    apb(1'b0, 8'h08, 32'h0);
    while (rd[5] !== 1'b0) begin
      n++;
      if (n > 1500) begin
        check("busy wait", 32'h0, 32'h1);
        completeRun();
      end
      apb(1'b0, 8'h08, 32'h0);
    end
  endtask

  task automatic press;
    dialToggle <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dialToggle <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  initial begin
    seedVal = $urandom(32'h1AD7);
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check("hookRelay", 32'h1, {31'h0, hookRelay});
    check("pulseDialing", 32'h0, {31'h0, pulseDialing});
    apb(1'b0, 8'h00, 32'h0);
    check("cfg reset", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    // tone dialing: digit taken, line untouched
    apb(1'b1, 8'h04, 32'h5);
    repeat (100) @(posedge ref_clk);
    check("tone pulses", 32'h0, {27'h0, pulses});
    check("tone relay", 32'h1, {31'h0, hookRelay});
    press();
    apb(1'b0, 8'h00, 32'h0);
    check("toggle open", 32'h80, rd);
    check("pulseDialing", 32'h1, {31'h0, pulseDialing});
    apb(1'b1, 8'h00, 32'h40);
    press();
    apb(1'b0, 8'h00, 32'h0);
    check("toggle locked", 32'h40, rd);
    check("pulseDialing", 32'h0, {31'h0, pulseDialing});
    for (int i = 0; i < 8; i++) begin
      gen = 2'(i);
      brk = 2'(i + 1);
      pau = 2'(i + 2);
      dig = (i == 0) ? 4'h0 : (i == 1) ? 4'h9 : 4'($urandom % 10);
      apb(1'b1, 8'h00, {24'h0, 1'b1, 1'($urandom), pau, brk, gen});
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      apb(1'b1, 8'h04, {28'h0, dig});
      apb(1'b1, 8'h04, 32'h3);
      waitIdle();
      check("pulses", expPulses(gen, dig), {27'h0, pulses});
      check("break", brkTab[brk], brkLen);
      if (pulses > 5'h01) begin
        check("period", brkTab[brk] + mkTab[brk], brkLen + mkLen);
      end
      checkSpan("pause", int'(mkTab[brk] + pauTab[pau]), snap);
    end
    // digits above nine or with upper bits set are refused
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    apb(1'b1, 8'h04, 32'hB);
    apb(1'b1, 8'h04, 32'h13);
    repeat (100) @(posedge ref_clk);
    check("refused digit", 32'h0, {27'h0, pulses});
    check("refused relay", 32'h1, {31'h0, hookRelay});
    completeRun();
  end
endmodule

// file: hdl/pdg_defines.svh
// constants of the pulse dial generator: offsets, fields, reset values, times
`ifndef PDG_DEFINES_SVH
`define PDG_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PDG_OFS_CFG 8'h00
`define PDG_OFS_DIGIT 8'h04
`define PDG_OFS_STAT 8'h08
// ----------------------------------------
// dial_pulse_config fields
// ----------------------------------------
`define PDG_CFG_GEN 1:0
`define PDG_CFG_BRK 3:2
`define PDG_CFG_PAUSE 5:4
`define PDG_CFG_LOCK 6
`define PDG_CFG_DFLT 7
`define PDG_CFG_RST 8'h00
`define PDG_DIGIT_MAX 4'h9
// ----------------------------------------
// pulse counts
// ----------------------------------------
`define PDG_PULSES_ZERO 4'hA
`define PDG_PULSES_BASE 4'hA
// ----------------------------------------
// times in ms, clock rate in kHz
// ----------------------------------------
`define PDG_BRK_A_MS 10'h03C
`define PDG_BRK_B_MS 10'h043
`define PDG_BRK_C_MS 10'h028
`define PDG_BRK_D_MS 10'h040
`define PDG_PERIOD_10PPS_MS 10'h064
`define PDG_MAKE_16PPS_MS 10'h016
`define PDG_PERIOD_D_MS 10'h06A
`define PDG_PAUSE_A_MS 10'h320
`define PDG_PAUSE_B_MS 10'h352
`define PDG_PAUSE_C_MS 10'h3B6
`define PDG_PAUSE_D_MS 10'h258
`define PDG_CLK_KHZ 32'h0003D090
`endif

// file: hdl/pdg_dial_if.sv
// link between register front end and pulse engine
`timescale 1ns/1ps
interface pdg_dial_if;
  pdg_pkg::pdg_sel_t genMode;
  pdg_pkg::pdg_sel_t brkSel;
  pdg_pkg::pdg_sel_t pauseSel;
  logic pulseMode;
  logic [3:0] digit;
  logic start;
  logic busy;
  logic [3:0] pulsesLeft;
  logic relayClosed;
  modport engine (input genMode, brkSel, pauseSel, pulseMode, digit, start,
                  output busy, pulsesLeft, relayClosed);
  modport ctrl (output genMode, brkSel, pauseSel, pulseMode, digit, start,
                input busy, pulsesLeft, relayClosed);
endinterface

// file: hdl/pdg_pkg.sv
// shared types of the pulse dial generator
package pdg_pkg;
  typedef enum logic [1:0] {
    PDG_IDLE,
    PDG_BREAK,
    PDG_MAKE,
    PDG_PAUSE
  } pdg_state_t;
  typedef logic [1:0] pdg_sel_t;
endpackage

// file: hdl/pdg_pulse_dial.sv
// pulse dial generator top: apb registers, dial-mode switch, pulse engine
// ----------------------------------------
// Summary of operation
// - pulse count: modes 00/11 give N, 01 gives N+1, 10 gives 10-N
// - in plain N mode digit zero gives ten pulses
// - break select 00/01/10 gives 60, 67, 40 ms breaks
// - break select 11 gives 64 ms break at 106 ms pulse period
// - inter-digit pause 800, 850, 950 or 600 ms by select
// - user toggle of dialing method only when lock bit is 0
// - default bit 0 selects tone dialing, 1 selects pulse dialing
// - accepted user toggle flips the stored default bit
// ----------------------------------------
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "pdg_defines.svh"
module pdg_pulse_dial #(
  parameter int unsigned CYC_PER_MS = `PDG_CLK_KHZ
) (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic dialToggle, // user dialing-method switch pin
  output logic hookRelay, // 1 closes the line loop
  output logic pulseDialing // 1 while pulse dialing selected
);
  pdg_dial_if dl ();
  logic [7:0] cfgQ;
  logic readyQ;
  logic errQ;
  logic [31:0] rdataQ;
  logic startQ;
  logic [3:0] digitQ;
  logic pulseQ;
  logic sync1Q;
  logic sync2Q;
  logic sync3Q;
  logic btnQ;
  logic pressEv;
  logic accEnd;
  logic wrCfg;
  logic wrDigit;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PDG_OFS_CFG) || (a == `PDG_OFS_DIGIT) || (a == `PDG_OFS_STAT);
  endfunction

  assign accEnd = psel && penable && readyQ;
  assign wrCfg = accEnd && pwrite && paddr == `PDG_OFS_CFG;
  assign wrDigit = accEnd && pwrite && paddr == `PDG_OFS_DIGIT;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readyQ <= 1'b0;
      errQ <= 1'b0;
    end else begin
      readyQ <= psel && penable && !readyQ;
      errQ <= psel && penable && !readyQ && !mapped(paddr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdataQ <= 32'h0;
    end else if (psel && penable && !readyQ && !pwrite) begin
      unique case (paddr)
        `PDG_OFS_CFG: rdataQ <= {24'h0, cfgQ};
        `PDG_OFS_DIGIT: rdataQ <= {28'h0, digitQ};
        `PDG_OFS_STAT: rdataQ <= {26'h0, dl.busy, cfgQ[`PDG_CFG_DFLT], dl.pulsesLeft};
        default: rdataQ <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // user switch: three-stage sync, agreed level
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync1Q <= 1'b0;
      sync2Q <= 1'b0;
      sync3Q <= 1'b0;
      btnQ <= 1'b0;
    end else begin
      sync1Q <= dialToggle;
      sync2Q <= sync1Q;
      sync3Q <= sync2Q;
      if (sync2Q == sync3Q) begin
        btnQ <= sync3Q;
      end
    end
  end

  assign pressEv = (sync2Q == sync3Q) && sync3Q && !btnQ;

  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfgQ <= `PDG_CFG_RST;
    end else begin
      if (wrCfg) begin
        cfgQ <= pwdata[7:0];
      end
      // switch press wins the default bit over a software write in the same cycle; bits 6:0 still take the write
      if (pressEv && !cfgQ[`PDG_CFG_LOCK]) begin
        cfgQ[`PDG_CFG_DFLT] <= !cfgQ[`PDG_CFG_DFLT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pulseQ <= 1'b0;
    end else begin
      pulseQ <= cfgQ[`PDG_CFG_DFLT];
    end
  end

  // ----------------------------------------
  // digit launch
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      startQ <= 1'b0;
      digitQ <= 4'h0;
    end else begin
      // dropped when busy, in tone dialing or out of range
      startQ <= wrDigit && !dl.busy && cfgQ[`PDG_CFG_DFLT]
                && pwdata[3:0] <= `PDG_DIGIT_MAX && pwdata[31:4] == 28'h0;
      if (wrDigit) begin
        digitQ <= pwdata[3:0];
      end
    end
  end

  assign dl.genMode = cfgQ[`PDG_CFG_GEN];
  assign dl.brkSel = cfgQ[`PDG_CFG_BRK];
  assign dl.pauseSel = cfgQ[`PDG_CFG_PAUSE];
  assign dl.pulseMode = cfgQ[`PDG_CFG_DFLT];
  assign dl.digit = digitQ;
  assign dl.start = startQ;

  pdg_pulse_engine #(.CYC_PER_MS(CYC_PER_MS)) i_pdg_pulse_engine (
    .clk(ref_clk),
    .rstB(rst_b),
    .dl(dl.engine)
  );

  assign prdata = rdataQ;
  assign pready = readyQ;
  assign pslverr = errQ;
  assign hookRelay = dl.relayClosed;
  assign pulseDialing = pulseQ;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_lock_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pressEv && cfgQ[`PDG_CFG_LOCK] && !wrCfg) |=> $stable(cfgQ))
    else $error("locked dialing method changed");
  chk_toggle_flip: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pressEv && !cfgQ[`PDG_CFG_LOCK])
    |=> cfgQ[`PDG_CFG_DFLT] != $past(cfgQ[`PDG_CFG_DFLT]))
    else $error("user toggle did not flip default bit");
  chk_mode_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 pulseDialing == $past(cfgQ[`PDG_CFG_DFLT]))
    else $error("dialing method output wrong");
  chk_tone_nopulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(dl.busy) |-> $past(cfgQ[`PDG_CFG_DFLT]))
    else $error("pulses started in tone dialing");
  chk_apb_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (psel && penable && !readyQ) |=> readyQ ##1 !readyQ)
    else $error("apb ready not one cycle");
  cov_toggle: cover property (@(posedge ref_clk) disable iff (!rst_b)
    pressEv && !cfgQ[`PDG_CFG_LOCK]);
  cov_unmapped: cover property (@(posedge ref_clk) disable iff (!rst_b) errQ);
  cov_locked_press: cover property (@(posedge ref_clk) disable iff (!rst_b)
    pressEv && cfgQ[`PDG_CFG_LOCK]);

  // ----------------------------------------
  // register and launch checks
  // ----------------------------------------
  chk_err_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (psel && penable && !readyQ && !mapped(paddr)) |=> pslverr && pready)
    else $error("unmapped access without error");
  chk_err_mapped: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (psel && penable && !readyQ && mapped(paddr)) |=> !pslverr && pready)
    else $error("mapped access flagged as error");
  chk_cfg_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrCfg && !pressEv) |=> cfgQ == $past(pwdata[7:0]))
    else $error("config write lost");
  chk_digit_store: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrDigit |=> digitQ == $past(pwdata[3:0]))
    else $error("digit write lost");
  chk_start_tone: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrDigit && !cfgQ[`PDG_CFG_DFLT]) |=> !startQ)
    else $error("digit launched in tone dialing");
  chk_start_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrDigit && dl.busy) |=> !startQ)
    else $error("digit launched while busy");
  chk_start_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrDigit && pwdata[3:0] > `PDG_DIGIT_MAX) |=> !startQ)
    else $error("digit above nine launched");
  chk_start_go: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrDigit && !dl.busy && cfgQ[`PDG_CFG_DFLT] && pwdata[3:0] <= `PDG_DIGIT_MAX
     && pwdata[31:4] == 28'h0) |=> startQ)
    else $error("valid digit not launched");
  chk_press_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pressEv |=> !pressEv)
    else $error("one press seen twice");
  chk_tone_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!pulseDialing && !dl.busy) |-> hookRelay)
    else $error("relay open while idle in tone dialing");
endmodule

// file: hdl/pdg_pulse_engine.sv
// break/make/pause sequencer driving the hook relay
`timescale 1ns/1ps
`include "pdg_defines.svh"
module pdg_pulse_engine #(
  parameter int unsigned CYC_PER_MS = `PDG_CLK_KHZ
) (
  input wire logic clk, // system clock
  input wire logic rstB, // synchronous reset, active low
  pdg_dial_if.engine dl // digit and timing link
);
  pdg_pkg::pdg_state_t stateQ;
  logic [31:0] timerQ;
  logic [3:0] leftQ;
  logic relayQ;

  // ----------------------------------------
  // timing decode
  // ----------------------------------------
  function automatic logic [31:0] cyc(input logic [9:0] ms);
    cyc = 32'(ms * CYC_PER_MS - 1);
  endfunction

  function automatic logic [9:0] brk_ms(input pdg_pkg::pdg_sel_t s);
    unique case (s)
      2'h0: brk_ms = `PDG_BRK_A_MS;
      2'h1: brk_ms = `PDG_BRK_B_MS;
      2'h2: brk_ms = `PDG_BRK_C_MS;
      2'h3: brk_ms = `PDG_BRK_D_MS;
    endcase
  endfunction

  function automatic logic [9:0] make_ms(input pdg_pkg::pdg_sel_t s);
    unique case (s)
      2'h2: make_ms = `PDG_MAKE_16PPS_MS;
      2'h3: make_ms = `PDG_PERIOD_D_MS - `PDG_BRK_D_MS;
      default: make_ms = `PDG_PERIOD_10PPS_MS - brk_ms(s);
    endcase
  endfunction

  function automatic logic [9:0] pause_ms(input pdg_pkg::pdg_sel_t s);
    unique case (s)
      2'h0: pause_ms = `PDG_PAUSE_A_MS;
      2'h1: pause_ms = `PDG_PAUSE_B_MS;
      2'h2: pause_ms = `PDG_PAUSE_C_MS;
      2'h3: pause_ms = `PDG_PAUSE_D_MS;
    endcase
  endfunction

  function automatic logic [3:0] pulses(input pdg_pkg::pdg_sel_t m, input logic [3:0] d);
    unique case (m)
      2'h1: pulses = d + 4'h1;
      2'h2: pulses = `PDG_PULSES_BASE - d;
      default: pulses = (d == 4'h0) ? `PDG_PULSES_ZERO : d;
    endcase
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstB) begin
      stateQ <= pdg_pkg::PDG_IDLE;
      timerQ <= 32'h0;
      relayQ <= 1'b1;
    end else begin
      unique case (stateQ)
        pdg_pkg::PDG_IDLE: begin
          relayQ <= 1'b1;
          if (dl.start && dl.pulseMode) begin
            stateQ <= pdg_pkg::PDG_BREAK;
            timerQ <= cyc(brk_ms(dl.brkSel));
            relayQ <= 1'b0;
          end
        end
        pdg_pkg::PDG_BREAK: begin
          if (timerQ == 32'h0) begin
            stateQ <= pdg_pkg::PDG_MAKE;
            timerQ <= cyc(make_ms(dl.brkSel));
            relayQ <= 1'b1;
          end else begin
            timerQ <= timerQ - 32'h1;
          end
        end
        pdg_pkg::PDG_MAKE: begin
          if (timerQ != 32'h0) begin
            timerQ <= timerQ - 32'h1;
          end else if (leftQ != 4'h0) begin
            stateQ <= pdg_pkg::PDG_BREAK;
            timerQ <= cyc(brk_ms(dl.brkSel));
            relayQ <= 1'b0;
          end else begin
            stateQ <= pdg_pkg::PDG_PAUSE;
            timerQ <= cyc(pause_ms(dl.pauseSel));
          end
        end
        pdg_pkg::PDG_PAUSE: begin
          if (timerQ == 32'h0) begin
            stateQ <= pdg_pkg::PDG_IDLE;
          end else begin
            timerQ <= timerQ - 32'h1;
          end
        end
      endcase
    end
  end

  // pulses still to break, counted down at each break end
  always_ff @(posedge clk) begin
    if (!rstB) begin
      leftQ <= 4'h0;
    end else if (stateQ == pdg_pkg::PDG_IDLE && dl.start && dl.pulseMode) begin
      leftQ <= pulses(dl.genMode, dl.digit);
    end else if (stateQ == pdg_pkg::PDG_BREAK && timerQ == 32'h0) begin
      leftQ <= leftQ - 4'h1;
    end
  end

  assign dl.busy = (stateQ != pdg_pkg::PDG_IDLE);
  assign dl.pulsesLeft = leftQ;
  assign dl.relayClosed = relayQ;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_count_load: assert property (@(posedge clk) disable iff (!rstB)
    (stateQ == pdg_pkg::PDG_IDLE && dl.start && dl.pulseMode && dl.genMode == 2'h2)
    |=> leftQ == `PDG_PULSES_BASE - $past(dl.digit))
    else $error("pulse count for 10-N mode wrong");
  chk_zero_ten: assert property (@(posedge clk) disable iff (!rstB)
    (stateQ == pdg_pkg::PDG_IDLE && dl.start && dl.pulseMode && dl.genMode == 2'h0
     && dl.digit == 4'h0) |=> leftQ == `PDG_PULSES_ZERO)
    else $error("digit zero does not give ten pulses");
  chk_break_time: assert property (@(posedge clk) disable iff (!rstB)
    $fell(relayQ) |-> timerQ == cyc(brk_ms($past(dl.brkSel))) && stateQ == pdg_pkg::PDG_BREAK)
    else $error("break time load wrong");
  chk_period_106: assert property (@(posedge clk) disable iff (!rstB)
    ($rose(relayQ) && $past(dl.brkSel) == 2'h3 && stateQ == pdg_pkg::PDG_MAKE)
    |-> timerQ + 32'h1 + cyc(`PDG_BRK_D_MS) + 32'h1 == cyc(`PDG_PERIOD_D_MS) + 32'h1)
    else $error("pulse interval not 106 ms");
  chk_pause_time: assert property (@(posedge clk) disable iff (!rstB)
    (stateQ == pdg_pkg::PDG_MAKE && timerQ == 32'h0 && leftQ == 4'h0)
    |=> stateQ == pdg_pkg::PDG_PAUSE && timerQ == cyc(pause_ms($past(dl.pauseSel))))
    else $error("inter-digit pause wrong");
  chk_tone_closed: assert property (@(posedge clk) disable iff (!rstB)
    (stateQ == pdg_pkg::PDG_IDLE && !dl.pulseMode) |=> relayQ)
    else $error("relay open in tone dialing");
  cov_full_digit: cover property (@(posedge clk) disable iff (!rstB)
    stateQ == pdg_pkg::PDG_PAUSE ##1 stateQ == pdg_pkg::PDG_IDLE);
  cov_fast_break: cover property (@(posedge clk) disable iff (!rstB)
    $fell(relayQ) && dl.brkSel == 2'h2);
endmodule
